// ---- rtl/sas_adc_seq.v ----
// Converter sequencer top: AXI4-Lite register file, mode control and result store
//
// Notes on behaviour
// - Ten-bit result resolved by successive approximation, most significant bit first.
// - Mode 00 disabled, 01 single start, 11 repeat; writing 00 aborts without storing.
// - Start bit written 1 begins conversion and clears itself once started.
// - Channel field code selects the analog input with that index.
// - Standby resets both control registers and blocks their writes until normal mode.
// - Time code sets 39, 78, 156, 312, 624 or 1248 clock periods.
// - Ladder bit connects ladder only while converting, or always.
// - Timing register bits 7 and 6 have no defined read value.
// - Status holds low result bits in 7:6, end flag 5, busy 4.
// - End flag reads 0 before or during a started conversion, 1 after and on through repeat restarts; read only.
// - Reading the upper result register clears the end flag.
// - Busy sets at start, clears at finish and on standby entry.
// - Status bits 3 to 0 carry no defined read value.
// - Completion stores result, sets end flag and pulses the done request together.
// - Repeat mode restarts automatically after each completion.
// - Upper result register holds the eight most significant result bits.
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.vh"

module sas_adc_seq (
	input wire clk_sys_in,
	input wire rst_in,
	input wire ce_in,
	input wire standby_mode_in,
	input wire comparator_in,
	input wire [7:0] s_axi_awaddr_in,
	input wire [2:0] s_axi_awprot_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [7:0] s_axi_araddr_in,
	input wire [2:0] s_axi_arprot_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	output wire [3:0] channel_select_out,
	output wire analog_input_disable_out,
	output reg ladder_connect_out,
	output wire sample_hold_out,
	output wire [9:0] dac_code_out,
	output reg conversion_done_irq_out
);

// ----------------------------------------
// Registers and core wires
// ----------------------------------------
reg [7:0] conversion_control_primary;
reg [5:0] conversion_timing_control;
reg [7:0] result_upper_register;
reg [1:0] result_low_bits;
reg end_of_conversion_flag;
reg [7:0] aw_addr;
reg aw_full;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_full;
reg [2:0] time_shift;
reg [31:0] next_rdata;
reg [1:0] next_rresp;
reg next_bresp_err;

wire [1:0] operating_mode_field;
wire start_conversion_bit;
wire mode_runs;
wire converter_busy_flag;
wire core_done;
wire [9:0] core_result;
wire start_go;
wire abort;
wire write_fire;
wire read_fire;
wire wr_lane0;
wire rd_upper;
wire [2:0] time_code;

assign operating_mode_field = conversion_control_primary[`SAS_CP_MODE_HI:`SAS_CP_MODE_LO];
assign start_conversion_bit = conversion_control_primary[`SAS_CP_START_BIT];
// Reserved code 10 counts as disabled
assign mode_runs = (operating_mode_field == `SAS_MODE_SINGLE) ||
	(operating_mode_field == `SAS_MODE_REPEAT);
// Repeat restarts in the completion cycle itself, no start write needed
assign start_go = mode_runs && !standby_mode_in && !converter_busy_flag &&
	(start_conversion_bit || (core_done && operating_mode_field == `SAS_MODE_REPEAT));
// Disabled or reserved mode, or standby, stops the conversion at once
assign abort = standby_mode_in || !mode_runs;
assign channel_select_out = conversion_control_primary[`SAS_CP_CHAN_HI:`SAS_CP_CHAN_LO];
assign analog_input_disable_out = conversion_control_primary[`SAS_CP_AIN_DIS_BIT];
assign time_code = conversion_timing_control[`SAS_TC_TIME_HI:`SAS_TC_TIME_LO];
assign write_fire = aw_full && w_full && !s_axi_bvalid_out;
assign read_fire = s_axi_arvalid_in && s_axi_arready_out;
assign wr_lane0 = w_strb[0];
assign rd_upper = read_fire && (s_axi_araddr_in == `SAS_ADDR_RESULT_UPPER);

// ----------------------------------------
// Conversion time decode
// ----------------------------------------
// Reserved codes fall back to the shortest time rather than stalling
always @*
begin
	case (time_code)
		3'h0: time_shift = 3'h0;
		3'h2: time_shift = 3'h1;
		3'h3: time_shift = 3'h2;
		3'h4: time_shift = 3'h3;
		3'h5: time_shift = 3'h4;
		3'h6: time_shift = 3'h5;
		default: time_shift = 3'h0;
	endcase
end

sas_sar_core u_core (
	.clk_sys_in(clk_sys_in),
	.rst_in(rst_in),
	.ce_in(ce_in),
	.start_in(start_go),
	.abort_in(abort),
	.time_shift_in(time_shift),
	.comparator_in(comparator_in),
	.busy_out(converter_busy_flag),
	.sample_hold_out(sample_hold_out),
	.dac_code_out(dac_code_out),
	.done_out(core_done),
	.result_out(core_result)
);

// ----------------------------------------
// Control registers
// ----------------------------------------
always @(posedge clk_sys_in)
begin
	if (rst_in)
	begin
		conversion_control_primary <= `SAS_CTRL_PRIMARY_RST;
		conversion_timing_control <= `SAS_TIMING_CTRL_RST;
	end
	else if (ce_in)
	begin
		if (standby_mode_in)
		begin
			// Held at initial value, writes dropped
			conversion_control_primary <= `SAS_CTRL_PRIMARY_RST;
			conversion_timing_control <= `SAS_TIMING_CTRL_RST;
		end
		else
		begin
			if (write_fire && wr_lane0 && aw_addr == `SAS_ADDR_CTRL_PRIMARY)
				conversion_control_primary <= w_data[7:0];
			else if (start_go)
				conversion_control_primary[`SAS_CP_START_BIT] <= 1'b0;
			if (write_fire && wr_lane0 && aw_addr == `SAS_ADDR_TIMING_CTRL)
				conversion_timing_control <= w_data[5:0];
		end
	end
end

// ----------------------------------------
// Result store and end flag
// ----------------------------------------
always @(posedge clk_sys_in)
begin
	if (rst_in)
	begin
		result_upper_register <= 8'h00;
		result_low_bits <= 2'h0;
		end_of_conversion_flag <= 1'b0;
		conversion_done_irq_out <= 1'b0;
		ladder_connect_out <= 1'b0;
	end
	else if (ce_in)
	begin
		conversion_done_irq_out <= core_done;
		// Ladder follows the flag's setting, dropped in standby
		ladder_connect_out <= !standby_mode_in &&
			(conversion_timing_control[`SAS_TC_LADDER_BIT] || converter_busy_flag || start_go);
		if (standby_mode_in)
		begin
			// Old results are lost on standby entry
			result_upper_register <= 8'h00;
			result_low_bits <= 2'h0;
			end_of_conversion_flag <= 1'b0;
		end
		else
		begin
			if (core_done)
			begin
				result_upper_register <= core_result[9:2];
				result_low_bits <= core_result[1:0];
			end
			// Completion wins over a clearing read in the same cycle
			if (core_done)
				end_of_conversion_flag <= 1'b1;
			else if (rd_upper || start_go)
				end_of_conversion_flag <= 1'b0;
		end
	end
end

// ----------------------------------------
// AXI4-Lite write channel
// ----------------------------------------
always @(posedge clk_sys_in)
begin
	if (rst_in)
	begin
		aw_addr <= 8'h00;
		aw_full <= 1'b0;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		w_full <= 1'b0;
		s_axi_awready_out <= 1'b1;
		s_axi_wready_out <= 1'b1;
		s_axi_bvalid_out <= 1'b0;
		s_axi_bresp_out <= `SAS_RESP_OKAY;
	end
	else if (ce_in)
	begin
		if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			aw_addr <= s_axi_awaddr_in;
			aw_full <= 1'b1;
			s_axi_awready_out <= 1'b0;
		end
		if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			w_data <= s_axi_wdata_in;
			w_strb <= s_axi_wstrb_in;
			w_full <= 1'b1;
			s_axi_wready_out <= 1'b0;
		end
		if (write_fire)
		begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= next_bresp_err ? `SAS_RESP_SLVERR : `SAS_RESP_OKAY;
		end
		else if (s_axi_bvalid_out && s_axi_bready_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
		end
	end
end

// Read-only and unmapped words answer with an error
always @*
begin
	next_bresp_err = !(aw_addr == `SAS_ADDR_CTRL_PRIMARY || aw_addr == `SAS_ADDR_TIMING_CTRL);
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @*
begin
	next_rdata = 32'h00000000;
	next_rresp = `SAS_RESP_OKAY;
	case (s_axi_araddr_in)
		`SAS_ADDR_CTRL_PRIMARY: next_rdata[7:0] = conversion_control_primary;
		// Undefined upper bits read as zero
		`SAS_ADDR_TIMING_CTRL: next_rdata[5:0] = conversion_timing_control;
		`SAS_ADDR_STATUS_LOW: next_rdata[7:0] = {result_low_bits, end_of_conversion_flag,
			converter_busy_flag, 4'h0};
		`SAS_ADDR_RESULT_UPPER: next_rdata[7:0] = result_upper_register;
		default: next_rresp = `SAS_RESP_SLVERR;
	endcase
end

// ----------------------------------------
// AXI4-Lite read channel
// ----------------------------------------
always @(posedge clk_sys_in)
begin
	if (rst_in)
	begin
		s_axi_arready_out <= 1'b1;
		s_axi_rvalid_out <= 1'b0;
		s_axi_rdata_out <= 32'h00000000;
		s_axi_rresp_out <= `SAS_RESP_OKAY;
	end
	else if (ce_in)
	begin
		if (read_fire)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= next_rdata;
			s_axi_rresp_out <= next_rresp;
		end
		else if (s_axi_rvalid_out && s_axi_rready_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end
end

endmodule
`default_nettype wire

// ---- rtl/sas_defines.vh ----
// Register map, field positions, codes and timing counts of the converter sequencer
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SAS_IDX_CTRL_PRIMARY 8'h0E
`define SAS_IDX_TIMING_CTRL 8'h0F
`define SAS_IDX_STATUS_LOW 8'h1E
`define SAS_IDX_RESULT_UPPER 8'h1F
`define SAS_ADDR_CTRL_PRIMARY 8'h38
`define SAS_ADDR_TIMING_CTRL 8'h3C
`define SAS_ADDR_STATUS_LOW 8'h78
`define SAS_ADDR_RESULT_UPPER 8'h7C
`define SAS_ADDR_W 8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SAS_CP_START_BIT 7
`define SAS_CP_MODE_HI 6
`define SAS_CP_MODE_LO 5
`define SAS_CP_AIN_DIS_BIT 4
`define SAS_CP_CHAN_HI 3
`define SAS_CP_CHAN_LO 0
`define SAS_TC_LADDER_BIT 5
`define SAS_TC_TIME_HI 3
`define SAS_TC_TIME_LO 1
`define SAS_ST_END_BIT 5
`define SAS_ST_BUSY_BIT 4

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SAS_CTRL_PRIMARY_RST 8'h00
`define SAS_TIMING_CTRL_RST 6'h00
`define SAS_MODE_DISABLED 2'h0
`define SAS_MODE_SINGLE 2'h1
`define SAS_MODE_RESERVED 2'h2
`define SAS_MODE_REPEAT 2'h3
`define SAS_RESP_OKAY 2'h0
`define SAS_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing counts in clock periods
// ----------------------------------------
`define SAS_STEP_CYC 9'h003
`define SAS_SAMPLE_CYC 9'h009

`endif

// ---- rtl/sas_sar_core.v ----
// Successive-approximation stepper: sample phase then ten compare steps
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.vh"

module sas_sar_core (
	input wire clk_sys_in,
	input wire rst_in,
	input wire ce_in,
	input wire start_in,
	input wire abort_in,
	input wire [2:0] time_shift_in,
	input wire comparator_in,
	output reg busy_out,
	output reg sample_hold_out,
	output reg [9:0] dac_code_out,
	output reg done_out,
	output reg [9:0] result_out
);

localparam ST_IDLE = 3'b001;
localparam ST_SAMPLE = 3'b010;
localparam ST_STEP = 3'b100;

reg [2:0] state;
reg [8:0] cnt;
reg [3:0] bit_pos;
wire [8:0] sample_len;
wire [8:0] step_len;
wire [9:0] kept;

// ----------------------------------------
// Phase lengths
// ----------------------------------------
// Whole conversion is 39 steps of 2^shift periods: 9 sampling, 3 per bit
assign sample_len = (`SAS_SAMPLE_CYC << time_shift_in) - 9'h001;
assign step_len = (`SAS_STEP_CYC << time_shift_in) - 9'h001;
// Comparator high keeps the trial bit
assign kept = comparator_in ? dac_code_out : (dac_code_out & ~(10'h001 << bit_pos));

// ----------------------------------------
// Sequencer
// ----------------------------------------
always @(posedge clk_sys_in)
begin
	if (rst_in)
	begin
		state <= ST_IDLE;
		cnt <= 9'h000;
		bit_pos <= 4'h0;
		busy_out <= 1'b0;
		sample_hold_out <= 1'b0;
		dac_code_out <= 10'h000;
		done_out <= 1'b0;
		result_out <= 10'h000;
	end
	else if (ce_in)
	begin
		done_out <= 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (start_in && !abort_in)
				begin
					state <= ST_SAMPLE;
					cnt <= sample_len;
					busy_out <= 1'b1;
					sample_hold_out <= 1'b1;
					dac_code_out <= 10'h000;
				end
			end
			ST_SAMPLE:
			begin
				if (abort_in)
				begin
					state <= ST_IDLE;
					busy_out <= 1'b0;
					sample_hold_out <= 1'b0;
				end
				else if (cnt == 9'h000)
				begin
					state <= ST_STEP;
					sample_hold_out <= 1'b0;
					bit_pos <= 4'h9;
					dac_code_out <= 10'h200;
					cnt <= step_len;
				end
				else
					cnt <= cnt - 9'h001;
			end
			ST_STEP:
			begin
				if (abort_in)
				begin
					// Aborted value is dropped, never stored
					state <= ST_IDLE;
					busy_out <= 1'b0;
					dac_code_out <= 10'h000;
				end
				else if (cnt != 9'h000)
					cnt <= cnt - 9'h001;
				else if (bit_pos == 4'h0)
				begin
					state <= ST_IDLE;
					result_out <= kept;
					done_out <= 1'b1;
					busy_out <= 1'b0;
					dac_code_out <= 10'h000;
				end
				else
				begin
					dac_code_out <= kept | (10'h001 << (bit_pos - 4'h1));
					bit_pos <= bit_pos - 4'h1;
					cnt <= step_len;
				end
			end
			default:
			begin
				state <= ST_IDLE;
				busy_out <= 1'b0;
				sample_hold_out <= 1'b0;
			end
		endcase
	end
end

endmodule
`default_nettype wire

// ---- sim/sas_comp_model.sv ----
// Behavioural comparator standing in for the analog front end
`timescale 1ns/10ps
`default_nettype none
module sas_comp_model (
	input wire logic [9:0] dac_code_in,
	input wire logic [9:0] level_in,
	output logic comparator_out
);
	// Ideal and noiseless, so a result must equal the level exactly
	assign comparator_out = (level_in >= dac_code_in);
endmodule
`default_nettype wire

// ---- sim/sas_adc_seq_asserts.sv ----
// Concurrent checks on the sequencer's analog-side outputs and its done request
`timescale 1ns/10ps
`default_nettype none
module sas_adc_seq_asserts (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic standby_mode_in,
	input wire logic [3:0] channel_select_out,
	input wire logic analog_input_disable_out,
	input wire logic ladder_connect_out,
	input wire logic sample_hold_out,
	input wire logic [9:0] dac_code_out,
	input wire logic conversion_done_irq_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	property p_trial_msb;
		$fell(sample_hold_out) && dac_code_out != 10'h000 |-> dac_code_out == 10'h200;
	endproperty
	a_trial_msb: assert property (p_trial_msb)
		else $error("first trial code not the top bit");
	property p_hold_no_trial;
		sample_hold_out |-> dac_code_out == 10'h000;
	endproperty
	a_hold_no_trial: assert property (p_hold_no_trial)
		else $error("trial code during sampling");
	// Shortest sampling phase is nine cycles
	property p_sample_len;
		$fell(sample_hold_out) && dac_code_out != 10'h000 |-> $past(sample_hold_out, 9);
	endproperty
	a_sample_len: assert property (p_sample_len)
		else $error("sampling phase too short");
	property p_irq_pulse;
		conversion_done_irq_out |=> !conversion_done_irq_out;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("done request longer than one cycle");
	// Last trial always has bit 0 set, two cycles before the request
	property p_irq_last_step;
		$rose(conversion_done_irq_out) |-> $past(dac_code_out[0], 2);
	endproperty
	a_irq_last_step: assert property (p_irq_last_step)
		else $error("done request without a final step");
	property p_ladder_busy;
		($past(sample_hold_out) && sample_hold_out) || ($past(dac_code_out) != 10'h000 && dac_code_out != 10'h000)
			|-> ladder_connect_out;
	endproperty
	a_ladder_busy: assert property (p_ladder_busy)
		else $error("ladder off during conversion");
	property p_standby_idle;
		standby_mode_in |=> !sample_hold_out && dac_code_out == 10'h000;
	endproperty
	a_standby_idle: assert property (p_standby_idle)
		else $error("conversion runs in standby");
	property p_standby_ctrl;
		standby_mode_in |=> channel_select_out == 4'h0 && !analog_input_disable_out && !ladder_connect_out;
	endproperty
	a_standby_ctrl: assert property (p_standby_ctrl)
		else $error("controls not cleared in standby");
endmodule
`default_nettype wire

// ---- sim/sas_adc_seq_test.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.vh"
module sas_adc_seq_test;
	logic clk_sys_in = 1'h0;
	logic rst_in = 1'h1;
	logic standby = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [9:0] level = 10'h000;
	logic awready, wready, bvalid, arready, rvalid, ain_dis, ladder, sh, irq, comp;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] chan;
	logic [9:0] dac;
	logic [65:0] exp_q [$];
	logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
	logic [9:0] lvl;
	logic [3:0] ch;
	int n;
	int base;
	int fail_count = 0;
	int checked = 0;
	int guard = 0;
	int irq_count = 0;

	sas_adc_seq dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'h1), .standby_mode_in(standby),
		.comparator_in(comp), .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.channel_select_out(chan), .analog_input_disable_out(ain_dis), .ladder_connect_out(ladder),
		.sample_hold_out(sh), .dac_code_out(dac), .conversion_done_irq_out(irq));
	sas_comp_model far (.dac_code_in(dac), .level_in(level), .comparator_out(comp));

	always #4 clk_sys_in = ~clk_sys_in;

	// ----------------------------------------
	// Bus tasks and scoreboard
	// ----------------------------------------
	task print_verdict;
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tmo;
		@(posedge clk_sys_in);
		guard++;
		if (guard > 3000)
		begin
			fail_count++;
			print_verdict();
		end
	endtask
	task idle(input int c);
		guard = 0;
		repeat (c) tmo();
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw;
		logic w;
		guard = 0;
		aw = 1'h1;
		w = 1'h1;
		@(posedge clk_sys_in);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (aw || w)
		begin
			tmo();
			if (aw && awready)
			begin
				aw = 1'h0;
				awvalid <= 1'h0;
			end
			if (w && wready)
			begin
				w = 1'h0;
				wvalid <= 1'h0;
			end
		end
		do tmo(); while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk("bresp", {32'h00000000, r}, {32'h00000000, bresp});
	endtask
	// Expected data, response and mask are queued for the read monitor
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic [1:0] r);
		guard = 0;
		exp_q.push_back({24'h000000, m, r, 24'h000000, e});
		@(posedge clk_sys_in);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do tmo(); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do tmo(); while (rvalid !== 1'h1);
		rready <= 1'h0;
	endtask
	always @(posedge clk_sys_in)
	begin
		if (rvalid === 1'h1 && rready)
		begin
			chk("rdata", exp_q[0][33:0], {rresp, rdata & exp_q[0][65:34]});
			void'(exp_q.pop_front());
		end
		if (irq === 1'h1)
			irq_count <= irq_count + 1;
	end

	initial
	begin
		void'($urandom(84));
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		rd(`SAS_ADDR_CTRL_PRIMARY, 8'h00, 8'hFF, `SAS_RESP_OKAY);
		rd(`SAS_ADDR_STATUS_LOW, 8'h00, 8'hF0, `SAS_RESP_OKAY);
		rd(8'h40, 8'h00, 8'hFF, `SAS_RESP_SLVERR);
		wr(`SAS_ADDR_STATUS_LOW, 8'hFF, `SAS_RESP_SLVERR);
		rd(`SAS_ADDR_STATUS_LOW, 8'h00, 8'hF0, `SAS_RESP_OKAY);
		// Analog level, channel and time code all change between conversions
		for (int i = 0; i < 6; i++)
		begin
			lvl = 10'($urandom);
			ch = 4'($urandom);
			level <= lvl;
			wr(`SAS_ADDR_TIMING_CTRL, {4'h1, codes[i], 1'h0}, `SAS_RESP_OKAY);
			rd(`SAS_ADDR_TIMING_CTRL, {4'h1, codes[i], 1'h0}, 8'h3F, `SAS_RESP_OKAY);
			wr(`SAS_ADDR_CTRL_PRIMARY, {4'h2, ch}, `SAS_RESP_OKAY);
			chk("channel", {30'h00000000, ch}, {30'h00000000, chan});
			wr(`SAS_ADDR_CTRL_PRIMARY, {4'hA, ch}, `SAS_RESP_OKAY);
			n = 0;
			guard = 0;
			do
			begin
				tmo();
				n++;
			end
			while (irq !== 1'h1);
			chk("cycles", (34'h27 << i) + 34'h2, 34'(n));
			rd(`SAS_ADDR_STATUS_LOW, {lvl[1:0], 6'h20}, 8'hF0, `SAS_RESP_OKAY);
			rd(`SAS_ADDR_RESULT_UPPER, lvl[9:2], 8'hFF, `SAS_RESP_OKAY);
			rd(`SAS_ADDR_STATUS_LOW, {lvl[1:0], 6'h00}, 8'hF0, `SAS_RESP_OKAY);
			rd(`SAS_ADDR_CTRL_PRIMARY, {4'h2, ch}, 8'hFF, `SAS_RESP_OKAY);
		end
		base = irq_count;
		// Input disable bit written along with disabled mode reaches its output
		wr(`SAS_ADDR_CTRL_PRIMARY, {4'h9, ch}, `SAS_RESP_OKAY);
		chk("ain_dis", 34'h1, {33'h0, ain_dis});
		wr(`SAS_ADDR_CTRL_PRIMARY, {4'hC, ch}, `SAS_RESP_OKAY);
		idle(80);
		chk("idle_irqs", 34'(base), 34'(irq_count));
		wr(`SAS_ADDR_TIMING_CTRL, 8'h10, `SAS_RESP_OKAY);
		wr(`SAS_ADDR_CTRL_PRIMARY, {4'hE, ch}, `SAS_RESP_OKAY);
		guard = 0;
		while (irq_count < base + 3) tmo();
		rd(`SAS_ADDR_STATUS_LOW, 8'h30, 8'h30, `SAS_RESP_OKAY);
		guard = 0;
		while (irq !== 1'h1) tmo();
		level <= ~lvl;
		idle(20);
		base = irq_count;
		wr(`SAS_ADDR_CTRL_PRIMARY, {4'h0, ch}, `SAS_RESP_OKAY);
		idle(80);
		chk("abort_irqs", 34'(base), 34'(irq_count));
		chk("ladder_off", 34'h0, {33'h0, ladder});
		rd(`SAS_ADDR_RESULT_UPPER, lvl[9:2], 8'hFF, `SAS_RESP_OKAY);
		// Standby in mid-conversion with the ladder held on
		wr(`SAS_ADDR_TIMING_CTRL, 8'h3C, `SAS_RESP_OKAY);
		// Ladder output is registered one edge behind the register
		idle(1);
		chk("ladder", 34'h1, {33'h0, ladder});
		wr(`SAS_ADDR_CTRL_PRIMARY, {4'hB, ch}, `SAS_RESP_OKAY);
		base = irq_count;
		idle(30);
		standby <= 1'h1;
		idle(10);
		wr(`SAS_ADDR_CTRL_PRIMARY, 8'h2F, `SAS_RESP_OKAY);
		standby <= 1'h0;
		idle(20);
		rd(`SAS_ADDR_CTRL_PRIMARY, 8'h00, 8'hFF, `SAS_RESP_OKAY);
		rd(`SAS_ADDR_TIMING_CTRL, 8'h00, 8'h3F, `SAS_RESP_OKAY);
		rd(`SAS_ADDR_STATUS_LOW, 8'h00, 8'h30, `SAS_RESP_OKAY);
		chk("standby_irqs", 34'(base), 34'(irq_count));
		print_verdict();
	end
endmodule

bind sas_adc_seq sas_adc_seq_asserts u_asserts (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.standby_mode_in(standby_mode_in), .channel_select_out(channel_select_out),
	.analog_input_disable_out(analog_input_disable_out), .ladder_connect_out(ladder_connect_out),
	.sample_hold_out(sample_hold_out), .dac_code_out(dac_code_out),
	.conversion_done_irq_out(conversion_done_irq_out));
`default_nettype wire
